// file: common/sdram_error_log_and_power_ctrl_regs.vh
// Purpose: Register indices, field positions and counts for the memory
//          controller error log and power control block.
// Assumes: Bit 0 of a documented field is the most significant bit, so
//          documented bit n sits at vector bit 31-n.
// Notes:   Definitions only.
`ifndef SDRAM_ERROR_LOG_AND_POWER_CTRL_REGS_VH
`define SDRAM_ERROR_LOG_AND_POWER_CTRL_REGS_VH

// ----------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------
`define IDX_SYNDROME_A      3'h0
`define IDX_SYNDROME_B      3'h1
`define IDX_IDLE_TIMER      3'h2
`define IDX_MEMCTL_CONFIG   3'h3
`define IDX_MEMCTL_STATE    3'h4

// ----------------------------------------------------------------------
// Syndrome A fields (vector bit positions)
// ----------------------------------------------------------------------
`define SA_FETCH_TYPE_HI    31
`define SA_FETCH_RD         28
`define SA_DSIDE_TYPE_HI    25
`define SA_DSIDE_RD         22
`define SA_EXT_TYPE_HI      19
`define SA_EXT_RD           16
`define SA_PCI_TYPE_HI      13
`define SA_PCI_RD           10
`define SA_PCI_FLOCK        9
`define SA_PCI_ALOCK        8
`define SA_MASK             32'hF3CF3F00

// ----------------------------------------------------------------------
// Syndrome B fields (vector bit positions)
// ----------------------------------------------------------------------
`define SB_MEDIA_TYPE_HI    31
`define SB_MEDIA_RD         28
`define SB_MEDIA_FLOCK      27
`define SB_MEDIA_ALOCK      26
`define SB_DMA_TYPE_HI      25
`define SB_DMA_RD           22
`define SB_MASK             32'hFFC00000

// ----------------------------------------------------------------------
// Error type codes and master numbers
// ----------------------------------------------------------------------
`define ERR_TYPE_NONE       3'h0
`define ERR_TYPE_UNCORR     3'h2
`define MST_FETCH           3'h0
`define MST_DSIDE           3'h1
`define MST_EXT             3'h2
`define MST_PCI             3'h3
`define MST_MEDIA           3'h4
`define MST_DMA             3'h5

// ----------------------------------------------------------------------
// Idle timer, config and state fields
// ----------------------------------------------------------------------
`define IT_CNT_HI           31
`define IT_CNT_LO           27
`define IT_ONES_HI          26
`define IT_ONES_LO          22
`define IT_ONES             5'h1F
`define IT_CNT_RESET        5'h00
`define CFG_SLEEP_ALLOW     31
`define CFG_SR_REQUEST      30
`define ST_SR_ACTIVE        31
`define ST_ASLEEP           30
`define WAKE_CYCLES         2'h2

// ----------------------------------------------------------------------
// Memory command codes
// ----------------------------------------------------------------------
`define CMD_NONE            3'h0
`define CMD_PRECHARGE_ALL   3'h1
`define CMD_AUTO_REFRESH    3'h2
`define CMD_SR_ENTER        3'h3
`define CMD_SR_EXIT         3'h4

`endif

// file: verilog/idle_sleep_timer.v
// Purpose: Counts idle memory clock cycles and flags the idle threshold.
// Assumes: Runs on the memory controller clock.
// Notes:   The hit flag is registered.
`timescale 1ns/1ps
module idle_sleep_timer
#(
  parameter WIDTH = 10
)
(
  // Clock and reset
  input  wire             sys_clk_in,
  input  wire             rst_n_in,
  // Control
  input  wire             restart_in,
  input  wire             advance_in,
  input  wire [WIDTH-1:0] threshold_in,
  // Status
  output reg              hit_out
);

  reg  [WIDTH-1:0] count_q;

  // ----------------------------------------------------------------------
  // Idle counter
  // ----------------------------------------------------------------------
  always @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      count_q <= {WIDTH{1'b0}};
      hit_out <= 1'b0;
    end
    else if (restart_in)
    begin
      count_q <= {WIDTH{1'b0}};
      hit_out <= 1'b0;
    end
    else if (advance_in)
    begin
      if (count_q == threshold_in)
        hit_out <= 1'b1;
      else
        count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule

// file: verilog/sdram_error_log_and_power_ctrl.v
// Purpose: Error syndrome logging, self-refresh sequencing and idle sleep
//          control for an SDRAM controller.
// Assumes: All inputs come from logic on sys_clk_in.
// Notes:   Registers are reached through a simple indexed register port.
`timescale 1ns/1ps
`include "sdram_error_log_and_power_ctrl_regs.vh"
module sdram_error_log_and_power_ctrl
(
  // Clock and reset
  input  wire        sys_clk_in,
  input  wire        rst_n_in,
  // Register port
  input  wire [2:0]  reg_index_in,
  input  wire        reg_write_in,
  input  wire        reg_read_in,
  input  wire [31:0] reg_wdata_in,
  output reg  [31:0] reg_rdata_out,
  // Uncorrectable error report
  input  wire        err_valid_in,
  input  wire [2:0]  err_master_in,
  input  wire        err_read_in,
  input  wire        err_lock_req_in,
  output reg         addr_capture_out,
  // System bus request side
  input  wire        mem_req_in,
  input  wire        req_queued_in,
  input  wire        op_busy_in,
  output reg         mem_accept_out,
  // Clock and power management
  input  wire        clock_power_sleep_enables_in,
  output reg         sleep_req_out,
  output reg         ctl_clock_en_out,
  // Memory command sequencer
  output reg  [2:0]  mem_cmd_out,
  input  wire        mem_cmd_ack_in,
  output reg         self_refresh_active_out
);

  // ----------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------
  localparam S_RUN      = 3'h0;
  localparam S_DRAIN    = 3'h1;
  localparam S_PRE      = 3'h2;
  localparam S_AREF_IN  = 3'h3;
  localparam S_ENTER    = 3'h4;
  localparam S_SELF     = 3'h5;
  localparam S_EXIT     = 3'h6;
  localparam S_AREF_OUT = 3'h7;

  reg  [31:0] syn_a_q;
  reg  [31:0] syn_a_d;
  reg  [31:0] syn_b_q;
  reg  [31:0] syn_b_d;
  reg  [31:0] set_a;
  reg  [31:0] set_b;
  reg  [31:0] load_a;
  reg  [31:0] load_b;
  reg  [4:0]  idle_cnt_q;
  reg         sleep_allow_q;
  reg         sr_request_q;
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg         asleep_q;
  reg  [1:0]  wake_q;
  reg         capture;
  wire        addr_locked;
  wire        wr_a;
  wire        wr_b;
  wire        reg_access;
  wire        timer_hit;
  wire        timer_restart;
  wire        timer_advance;
  wire        sleep_enter;

  // Places a three bit type and a read flag at a field.
  function [31:0] field_put;
    input integer hi;
    input         rd;
    begin
      field_put = 32'h00000000;
      field_put[hi]   = 1'b0;
      field_put[hi-1] = 1'b1;
      field_put[hi-2] = 1'b0;
      field_put[hi-3] = rd;
    end
  endfunction

  assign addr_locked = syn_a_q[`SA_PCI_ALOCK] | syn_b_q[`SB_MEDIA_ALOCK];
  assign wr_a = reg_write_in && (reg_index_in == `IDX_SYNDROME_A);
  assign wr_b = reg_write_in && (reg_index_in == `IDX_SYNDROME_B);
  assign reg_access = reg_write_in | reg_read_in;

  // ----------------------------------------------------------------------
  // Error logging
  // ----------------------------------------------------------------------
  always @*
  begin
    set_a = 32'h00000000;
    set_b = 32'h00000000;
    load_a = 32'h00000000;
    load_b = 32'h00000000;
    capture = 1'b0;
    if (err_valid_in)
    begin
      capture = !addr_locked;
      case (err_master_in)
        `MST_FETCH:
        begin
          set_a = field_put(`SA_FETCH_TYPE_HI, err_read_in);
          load_a = field_put(`SA_FETCH_TYPE_HI, 1'b1);
        end
        `MST_DSIDE:
        begin
          set_a = field_put(`SA_DSIDE_TYPE_HI, err_read_in);
          load_a = field_put(`SA_DSIDE_TYPE_HI, 1'b1);
        end
        `MST_EXT:
        begin
          set_a = field_put(`SA_EXT_TYPE_HI, err_read_in);
          load_a = field_put(`SA_EXT_TYPE_HI, 1'b1);
        end
        `MST_PCI:
        begin
          if (!syn_a_q[`SA_PCI_FLOCK])
          begin
            set_a = field_put(`SA_PCI_TYPE_HI, err_read_in);
            load_a = field_put(`SA_PCI_TYPE_HI, 1'b1);
            if (err_lock_req_in)
            begin
              set_a[`SA_PCI_FLOCK] = 1'b1;
              set_a[`SA_PCI_ALOCK] = !addr_locked;
            end
          end
        end
        `MST_MEDIA:
        begin
          if (!syn_b_q[`SB_MEDIA_FLOCK])
          begin
            set_b = field_put(`SB_MEDIA_TYPE_HI, err_read_in);
            load_b = field_put(`SB_MEDIA_TYPE_HI, 1'b1);
            if (err_lock_req_in)
            begin
              set_b[`SB_MEDIA_FLOCK] = 1'b1;
              set_b[`SB_MEDIA_ALOCK] = !addr_locked;
            end
          end
        end
        `MST_DMA:
        begin
          set_b = field_put(`SB_DMA_TYPE_HI, err_read_in);
          load_b = field_put(`SB_DMA_TYPE_HI, 1'b1);
        end
        default:
        begin
          capture = 1'b0;
        end
      endcase
    end
    // A bit set by an error in the clearing cycle survives the clear.
    syn_a_d = (syn_a_q & ~(wr_a ? reg_wdata_in : 32'h00000000) & ~load_a)
              | set_a;
    syn_b_d = (syn_b_q & ~(wr_b ? reg_wdata_in : 32'h00000000) & ~load_b)
              | set_b;
  end

  always @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      syn_a_q <= 32'h00000000;
      syn_b_q <= 32'h00000000;
      addr_capture_out <= 1'b0;
    end
    else
    begin
      syn_a_q <= syn_a_d & `SA_MASK;
      syn_b_q <= syn_b_d & `SB_MASK;
      addr_capture_out <= capture;
    end
  end

  // ----------------------------------------------------------------------
  // Configuration registers and read data
  // ----------------------------------------------------------------------
  always @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      idle_cnt_q <= `IT_CNT_RESET;
      sleep_allow_q <= 1'b0;
      sr_request_q <= 1'b0;
      reg_rdata_out <= 32'h00000000;
    end
    else
    begin
      if (reg_write_in && (reg_index_in == `IDX_IDLE_TIMER))
        idle_cnt_q <= reg_wdata_in[`IT_CNT_HI:`IT_CNT_LO];
      if (reg_write_in && (reg_index_in == `IDX_MEMCTL_CONFIG))
      begin
        sleep_allow_q <= reg_wdata_in[`CFG_SLEEP_ALLOW];
        sr_request_q <= reg_wdata_in[`CFG_SR_REQUEST];
      end
      if (reg_read_in)
      begin
        reg_rdata_out <= 32'h00000000;
        case (reg_index_in)
          `IDX_SYNDROME_A:
            reg_rdata_out <= syn_a_q;
          `IDX_SYNDROME_B:
            reg_rdata_out <= syn_b_q;
          `IDX_IDLE_TIMER:
          begin
            reg_rdata_out[`IT_CNT_HI:`IT_CNT_LO] <= idle_cnt_q;
            reg_rdata_out[`IT_ONES_HI:`IT_ONES_LO] <= `IT_ONES;
          end
          `IDX_MEMCTL_CONFIG:
          begin
            reg_rdata_out[`CFG_SLEEP_ALLOW] <= sleep_allow_q;
            reg_rdata_out[`CFG_SR_REQUEST] <= sr_request_q;
          end
          `IDX_MEMCTL_STATE:
          begin
            reg_rdata_out[`ST_SR_ACTIVE] <= self_refresh_active_out;
            reg_rdata_out[`ST_ASLEEP] <= asleep_q;
          end
          default:
            reg_rdata_out <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Self-refresh sequencer
  // ----------------------------------------------------------------------
  always @*
  begin
    state_d = state_q;
    case (state_q)
      S_RUN:
        if (sr_request_q && !asleep_q && wake_q == 2'h0)
          state_d = S_DRAIN;
      S_DRAIN:
        if (!op_busy_in)
          state_d = S_PRE;
      S_PRE:
        if (mem_cmd_ack_in)
          state_d = S_AREF_IN;
      S_AREF_IN:
        if (mem_cmd_ack_in)
          state_d = S_ENTER;
      S_ENTER:
        if (mem_cmd_ack_in)
          state_d = S_SELF;
      S_SELF:
        if (!sr_request_q)
          state_d = S_EXIT;
      S_EXIT:
        if (mem_cmd_ack_in)
          state_d = S_AREF_OUT;
      S_AREF_OUT:
        if (mem_cmd_ack_in)
          state_d = S_RUN;
      default:
        state_d = S_RUN;
    endcase
  end

  always @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= S_RUN;
      mem_cmd_out <= `CMD_NONE;
      self_refresh_active_out <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      case (state_d)
        S_PRE:
          mem_cmd_out <= `CMD_PRECHARGE_ALL;
        S_AREF_IN:
          mem_cmd_out <= `CMD_AUTO_REFRESH;
        S_ENTER:
          mem_cmd_out <= `CMD_SR_ENTER;
        S_EXIT:
          mem_cmd_out <= `CMD_SR_EXIT;
        S_AREF_OUT:
          mem_cmd_out <= `CMD_AUTO_REFRESH;
        default:
          mem_cmd_out <= `CMD_NONE;
      endcase
      if (state_q == S_ENTER && mem_cmd_ack_in)
        self_refresh_active_out <= 1'b1;
      else if (state_q == S_AREF_OUT && mem_cmd_ack_in)
        self_refresh_active_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Sleep control
  // ----------------------------------------------------------------------
  assign timer_restart = mem_req_in | reg_access | req_queued_in
                         | op_busy_in | asleep_q;
  assign timer_advance = sleep_allow_q & clock_power_sleep_enables_in
                         & (state_q == S_RUN) & (wake_q == 2'h0);
  assign sleep_enter = !asleep_q & timer_hit & timer_advance
                       & !timer_restart;

  idle_sleep_timer
  #(
    .WIDTH        (10)
  )
  u_idle_timer
  (
    .sys_clk_in   (sys_clk_in),
    .rst_n_in     (rst_n_in),
    .restart_in   (timer_restart),
    .advance_in   (timer_advance),
    .threshold_in ({idle_cnt_q, `IT_ONES}),
    .hit_out      (timer_hit)
  );

  always @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      asleep_q <= 1'b0;
      wake_q <= 2'h0;
      sleep_req_out <= 1'b0;
      ctl_clock_en_out <= 1'b1;
      mem_accept_out <= 1'b0;
    end
    else
    begin
      if (asleep_q && (mem_req_in || reg_access))
      begin
        asleep_q <= 1'b0;
        wake_q <= `WAKE_CYCLES;
        sleep_req_out <= 1'b0;
        ctl_clock_en_out <= 1'b1;
      end
      else if (sleep_enter)
      begin
        asleep_q <= 1'b1;
        sleep_req_out <= 1'b1;
        ctl_clock_en_out <= 1'b0;
      end
      else if (wake_q != 2'h0)
        wake_q <= wake_q - 2'h1;
      mem_accept_out <= (state_d == S_RUN) && !asleep_q
                        && (wake_q <= 2'h1)
                        && !sleep_enter;
    end
  end

endmodule

// file: testbench/sdram_ctrl_asserts.sv
// Purpose: Concurrent checks on the ports of the memory controller block.
// Assumes: One clock domain, reset asynchronous and active low.
// Notes:   Attached by bind from the testbench top.
`timescale 1ns/1ps
`include "sdram_error_log_and_power_ctrl_regs.vh"
module sdram_ctrl_asserts
(
  // Clock and reset
  input wire        sys_clk_in,
  input wire        rst_n_in,
  // Register port
  input wire [2:0]  reg_index_in,
  input wire        reg_write_in,
  input wire        reg_read_in,
  input wire [31:0] reg_wdata_in,
  input wire [31:0] reg_rdata_out,
  // Error report
  input wire        err_valid_in,
  input wire [2:0]  err_master_in,
  input wire        err_read_in,
  input wire        err_lock_req_in,
  input wire        addr_capture_out,
  // System bus
  input wire        mem_req_in,
  input wire        req_queued_in,
  input wire        op_busy_in,
  input wire        mem_accept_out,
  // Power and commands
  input wire        clock_power_sleep_enables_in,
  input wire        sleep_req_out,
  input wire        ctl_clock_en_out,
  input wire [2:0]  mem_cmd_out,
  input wire        mem_cmd_ack_in,
  input wire        self_refresh_active_out
);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_cmd_held: assert property (mem_cmd_out != `CMD_NONE && !mem_cmd_ack_in
    |=> mem_cmd_out == $past(mem_cmd_out)) else $error("command dropped");
  a_precharge_refresh: assert property (mem_cmd_ack_in &&
    mem_cmd_out == `CMD_PRECHARGE_ALL |=> mem_cmd_out == `CMD_AUTO_REFRESH)
    else $error("no refresh after precharge");
  a_enter_status: assert property (mem_cmd_ack_in &&
    mem_cmd_out == `CMD_SR_ENTER |=> self_refresh_active_out)
    else $error("self refresh status not set");
  a_busy_stall: assert property (mem_cmd_out != `CMD_NONE
    |-> !mem_accept_out) else $error("accept during sequence");
  a_sr_stall: assert property (self_refresh_active_out
    |-> !mem_accept_out) else $error("accept in self refresh");
  a_exit_refresh: assert property (mem_cmd_ack_in &&
    mem_cmd_out == `CMD_SR_EXIT |=> mem_cmd_out == `CMD_AUTO_REFRESH)
    else $error("no refresh after exit");
  a_exit_clear: assert property ($fell(self_refresh_active_out) |->
    mem_accept_out && $past(mem_cmd_out) == `CMD_AUTO_REFRESH)
    else $error("bad self refresh exit");
  a_sleep_gated: assert property (sleep_req_out |->
    !ctl_clock_en_out && !mem_accept_out) else $error("clock not gated");
  a_sleep_enabled: assert property ($rose(sleep_req_out)
    |-> $past(clock_power_sleep_enables_in)) else $error("sleep disabled");
  a_wake_event: assert property (sleep_req_out && (mem_req_in ||
    reg_read_in || reg_write_in) |=> !sleep_req_out) else $error("no wake");
  a_wake_latency: assert property ($fell(sleep_req_out) |->
    !mem_accept_out ##1 !mem_accept_out ##1 mem_accept_out)
    else $error("wake latency wrong");
endmodule

// file: testbench/mem_partner.sv
// Purpose: Behavioural memory device answering sequencer commands.
// Assumes: Commands are held until acknowledged.
// Notes:   Answer delay is set by the bench, zero for prompt replies.
`timescale 1ns/1ps
`include "sdram_error_log_and_power_ctrl_regs.vh"
module mem_partner
(
  // Clock and reset
  input  wire       sys_clk_in,
  input  wire       rst_n_in,
  // Command side
  input  wire [2:0] mem_cmd_in,
  input  wire [3:0] delay_in,
  output reg        mem_cmd_ack_out
);
  reg [3:0] wait_q;
  // ----------------------------------------------------------------
  // Acknowledge each command once after the programmed delay.
  // ----------------------------------------------------------------
  always @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wait_q          <= 4'h0;
      mem_cmd_ack_out <= 1'h0;
    end
    else if (mem_cmd_in == `CMD_NONE || mem_cmd_ack_out)
    begin
      wait_q          <= 4'h0;
      mem_cmd_ack_out <= 1'h0;
    end
    else if (wait_q >= delay_in)
      mem_cmd_ack_out <= 1'h1;
    else
      wait_q <= wait_q + 4'h1;
  end
endmodule

// file: testbench/tb_top.sv
// Purpose: Self-checking bench for the error log and power control block.
// Assumes: Inputs change 1 ns after the rising clock edge.
// Notes:   Register reads are scored through a queue of expected words.
`timescale 1ns/1ps
`include "sdram_error_log_and_power_ctrl_regs.vh"
module tb_top;
  logic        sys_clk_in, rst_n_in, reg_write_in, reg_read_in;
  logic [2:0]  reg_index_in, err_master_in;
  logic [31:0] reg_wdata_in, exp_a, exp_b, rnd;
  logic        err_valid_in, err_read_in, err_lock_req_in, mem_req_in;
  logic        req_queued_in, op_busy_in, clock_power_sleep_enables_in;
  logic [3:0]  ack_delay;
  logic        rd_flag, cap;
  wire  [31:0] reg_rdata_out;
  wire  [2:0]  mem_cmd_out;
  wire         addr_capture_out, mem_accept_out, sleep_req_out;
  wire         ctl_clock_en_out, mem_cmd_ack_in, self_refresh_active_out;
  logic [31:0] exp_q[$];
  logic [2:0]  cmd_log[$];
  int          n_errors, checks_done, i, p, n0, n1;

  sdram_error_log_and_power_ctrl sdram_error_log_and_power_ctrl_inst (
    .sys_clk_in, .rst_n_in, .reg_index_in, .reg_write_in, .reg_read_in,
    .reg_wdata_in, .reg_rdata_out, .err_valid_in, .err_master_in,
    .err_read_in, .err_lock_req_in, .addr_capture_out, .mem_req_in,
    .req_queued_in, .op_busy_in, .mem_accept_out,
    .clock_power_sleep_enables_in, .sleep_req_out, .ctl_clock_en_out,
    .mem_cmd_out, .mem_cmd_ack_in, .self_refresh_active_out);
  mem_partner mem_partner_inst (.sys_clk_in, .rst_n_in,
    .mem_cmd_in(mem_cmd_out), .delay_in(ack_delay),
    .mem_cmd_ack_out(mem_cmd_ack_in));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task conclude;
    $display("checks %0d, errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task check(input string what, input logic [31:0] seen,
             input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task reg_wr(input logic [2:0] idx, input logic [31:0] data);
    reg_index_in = idx;
    reg_wdata_in = data;
    reg_write_in = 1'h1;
    @(posedge sys_clk_in);
    #1 reg_write_in = 1'h0;
    @(posedge sys_clk_in);
    #1;
  endtask
  task reg_rd(input logic [2:0] idx, input logic [31:0] exp);
    reg_index_in = idx;
    reg_read_in = 1'h1;
    exp_q.push_back(exp);
    @(posedge sys_clk_in);
    #1 reg_read_in = 1'h0;
    @(posedge sys_clk_in);
    #1;
  endtask
  task err(input int m, input logic rd, input logic lk);
    err_master_in = m[2:0];
    err_read_in = rd;
    err_lock_req_in = lk;
    err_valid_in = 1'h1;
    @(posedge sys_clk_in);
    #1 err_valid_in = 1'h0;
    cap = addr_capture_out;
    @(posedge sys_clk_in);
    #1;
  endtask
  task log_err(input int m, input logic rd);
    int hi;
    hi = (m == 0 || m == 4) ? 31 : (m == 1 || m == 5) ? 25 : (m == 2) ? 19 : 13;
    if (m < 4)
      exp_a[hi -: 4] = {`ERR_TYPE_UNCORR, rd};
    else
      exp_b[hi -: 4] = {`ERR_TYPE_UNCORR, rd};
  endtask
  task wait_until(input int sel, input logic lvl, output int n);
    logic v;
    n = 0;
    v = ~lvl;
    while (v !== lvl)
    begin
      @(posedge sys_clk_in);
      #1 n++;
      v = sel == 0 ? sleep_req_out : sel == 1 ? self_refresh_active_out
                                              : mem_accept_out;
      if (n > 400)
      begin
        n_errors++;
        $display("unexpected timeout on signal %0d", sel);
        conclude;
      end
    end
  endtask
  task check_cmds(input logic [31:0] exp);
    logic [31:0] packed_v;
    packed_v = 32'h0;
    while (cmd_log.size() > 0)
      packed_v = {packed_v[27:0], 1'h0, cmd_log.pop_front()};
    check("command order", packed_v, exp);
  endtask
  task measure(input logic [4:0] cnt, output int n);
    int m;
    req_queued_in = 1'h1;
    reg_wr(`IDX_IDLE_TIMER, {cnt, 27'h0});
    repeat (40) @(posedge sys_clk_in);
    #1 check("sleep while queued", {31'h0, sleep_req_out}, 32'h0);
    req_queued_in = 1'h0;
    wait_until(0, 1'h1, n);
    mem_req_in = 1'h1;
    @(posedge sys_clk_in);
    #1 check("sleep after request", {31'h0, sleep_req_out}, 32'h0);
    wait_until(2, 1'h1, m);
    mem_req_in = 1'h0;
  endtask

  // ----------------------------------------------------------------
  // Clock, monitors and scoring
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk_in = 1'h0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in)
  begin
    rd_flag <= reg_read_in;
    if (rst_n_in && mem_cmd_ack_in)
      cmd_log.push_back(mem_cmd_out);
  end
  always @(negedge sys_clk_in)
    if (rd_flag)
    begin
      if (exp_q.size() == 0)
        check("read queue", 32'h1, 32'h0);
      else
        check("register", reg_rdata_out, exp_q.pop_front());
    end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {rst_n_in, reg_write_in, reg_read_in, err_valid_in, err_read_in} = 5'h0;
    {err_lock_req_in, mem_req_in, req_queued_in, op_busy_in} = 4'h0;
    clock_power_sleep_enables_in = 1'h0;
    {reg_index_in, err_master_in, reg_wdata_in} = 38'h0;
    {exp_a, exp_b, ack_delay} = 68'h0;
    n_errors = 0;
    checks_done = 0;
    rnd = $urandom(32'h0F74);
    repeat (4) @(posedge sys_clk_in);
    #1 rst_n_in = 1'h1;
    reg_rd(`IDX_SYNDROME_A, 32'h0);
    reg_rd(`IDX_SYNDROME_B, 32'h0);
    reg_rd(`IDX_IDLE_TIMER, 32'h07C00000);
    reg_rd(3'h5, 32'h0);
    rnd = $urandom;
    for (p = 0; p < 2; p++)
    begin
      for (i = 0; i < 6; i++)
      begin
        err(i, rnd[i] ^ p[0], 1'h0);
        log_err(i, rnd[i] ^ p[0]);
        check("capture", {31'h0, cap}, 32'h1);
      end
      reg_rd(`IDX_SYNDROME_A, exp_a);
      reg_rd(`IDX_SYNDROME_B, exp_b);
    end
    rnd = $urandom;
    reg_wr(`IDX_SYNDROME_A, rnd);
    reg_wr(`IDX_SYNDROME_B, ~rnd);
    reg_rd(`IDX_SYNDROME_A, exp_a & ~rnd);
    reg_rd(`IDX_SYNDROME_B, exp_b & rnd);
    reg_wr(`IDX_SYNDROME_A, 32'hFFFFFFFF);
    reg_wr(`IDX_SYNDROME_B, 32'hFFFFFFFF);
    err(3, 1'h1, 1'h1);
    check("capture pci", {31'h0, cap}, 32'h1);
    err(3, 1'h0, 1'h1);
    check("capture held", {31'h0, cap}, 32'h0);
    reg_rd(`IDX_SYNDROME_A, 32'h00001700);
    err(4, 1'h1, 1'h1);
    err(0, 1'h1, 1'h1);
    check("capture fetch", {31'h0, cap}, 32'h0);
    reg_rd(`IDX_SYNDROME_B, 32'h58000000);
    reg_rd(`IDX_SYNDROME_A, 32'h50001700);
    reg_wr(`IDX_SYNDROME_A, 32'h00003F00);
    err(5, 1'h0, 1'h1);
    check("capture dma", {31'h0, cap}, 32'h1);
    reg_rd(`IDX_SYNDROME_A, 32'h50000000);
    reg_rd(`IDX_SYNDROME_B, 32'h59000000);
    // Queue drained first; the current operation is still running.
    ack_delay = 4'h3;
    op_busy_in = 1'h1;
    reg_wr(`IDX_MEMCTL_CONFIG, 32'h40000000);
    repeat (6) @(posedge sys_clk_in);
    #1 check("command while busy", {29'h0, mem_cmd_out}, 32'h0);
    op_busy_in = 1'h0;
    wait_until(1, 1'h1, n0);
    check_cmds(32'h00000123);
    mem_req_in = 1'h1;
    repeat (8) @(posedge sys_clk_in);
    #1 check("accept in refresh", {31'h0, mem_accept_out}, 32'h0);
    reg_rd(`IDX_MEMCTL_STATE, 32'h80000000);
    ack_delay = 4'h0;
    reg_wr(`IDX_MEMCTL_CONFIG, 32'h0);
    wait_until(1, 1'h0, n0);
    check("accept after exit", {31'h0, mem_accept_out}, 32'h1);
    check_cmds(32'h00000042);
    mem_req_in = 1'h0;
    reg_wr(`IDX_MEMCTL_CONFIG, 32'h80000000);
    repeat (90) @(posedge sys_clk_in);
    #1 check("sleep one enable", {31'h0, sleep_req_out}, 32'h0);
    clock_power_sleep_enables_in = 1'h1;
    measure(5'h00, n0);
    check("idle wait", 32'(n0), 32'h21);
    measure(5'h01, n1);
    check("idle span", 32'(n1 - n0), 32'h20);
    wait_until(0, 1'h1, n1);
    reg_wr(`IDX_MEMCTL_CONFIG, 32'h0);
    check("wake by write", {31'h0, sleep_req_out}, 32'h0);
    clock_power_sleep_enables_in = 1'h0;
    repeat (4) @(posedge sys_clk_in);
    conclude;
  end
endmodule

bind sdram_error_log_and_power_ctrl sdram_ctrl_asserts sdram_ctrl_asserts_inst (
  .sys_clk_in, .rst_n_in, .reg_index_in, .reg_write_in, .reg_read_in,
  .reg_wdata_in, .reg_rdata_out, .err_valid_in, .err_master_in,
  .err_read_in, .err_lock_req_in, .addr_capture_out, .mem_req_in,
  .req_queued_in, .op_busy_in, .mem_accept_out,
  .clock_power_sleep_enables_in, .sleep_req_out, .ctl_clock_en_out,
  .mem_cmd_out, .mem_cmd_ack_in, .self_refresh_active_out);
